// [core/ulp_pkg.sv]
// ulp package: register map, field positions and bus carriers
package ulp_pkg;
  // word indices of both register sets (byte address / 4; 16-bit words, 32-bit bus)
  localparam logic [11:0] MODE1_OFS = 12'h020c;
  localparam logic [11:0] STAT1_OFS = 12'h020e;
  localparam logic [11:0] TXW1_OFS  = 12'h0210;
  localparam logic [11:0] RXW1_OFS  = 12'h0212;
  localparam logic [11:0] BAUD1_OFS = 12'h0214;
  localparam logic [11:0] MODE2_OFS = 12'h0216;
  localparam logic [11:0] STAT2_OFS = 12'h0218;
  localparam logic [11:0] TXW2_OFS  = 12'h021a;
  localparam logic [11:0] RXW2_OFS  = 12'h021c;
  localparam logic [11:0] BAUD2_OFS = 12'h021e;
  localparam logic [11:0] IRQST_OFS = 12'h0300;
  localparam logic [11:0] IRQMSK_OFS = 12'h0304;
  localparam logic [11:0] PWR_OFS   = 12'h0308;
  // mode fields
  localparam int MODE_ON    = 15;
  localparam int MODE_IDLEH = 13;
  localparam int MODE_ALT   = 10;
  localparam int MODE_WAKE  = 7;
  localparam int MODE_LOOP  = 6;
  localparam int MODE_AUTORATE_CAPTURE_ON = 5;
  // status fields
  localparam int ST_TXISEL = 15;
  localparam int ST_BRK    = 11;
  localparam int ST_TXON   = 10;
  localparam int ST_TXBF   = 9;
  localparam int ST_EMPTY  = 8;
  localparam int ST_ADDR_DETECT_ON  = 5;
  localparam int ST_QUIET  = 4;
  localparam int ST_PARITY_FAULT   = 3;
  localparam int ST_FRAMING_FAULT   = 2;
  localparam int ST_OVERRUN_FAULT   = 1;
  localparam int ST_AVAIL  = 0;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0110;
  // software-writable status bits
  localparam logic [15:0] STAT_WMASK = 16'h8ce2;
  localparam logic [15:0] MODE1_MASK = 16'ha4e7;
  localparam logic [15:0] MODE2_MASK = 16'ha0e7;
  localparam int OVERSAMPLE = 16;
  localparam int FRAME_BITS = 10;
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ulp_apb_req_type;
  typedef struct packed {
    logic        sleep;
    logic        idle;
  } ulp_power_type;
endpackage : ulp_pkg

// [core/ulp_uart_pair.sv]
// ulp two-channel serial unit: sleep/idle handling and register file
// Operation
// RULE1: sleep stops and holds unit clocks low; here clk is not gated, unitRun drops instead
// RULE2: sleep aborts transmit, output line high
// RULE3: sleep aborts any reception in progress
// RULE4: sleep leaves all registers unchanged; here status bits EMPTY, TXBF and QUIET still update
// RULE5: edge-wake: falling input edge raises rx flag
// RULE6: rx level select ignored for edge-wake
// RULE7: edge wakes device only if rx enabled
// RULE8: edge-wake works only with unit on
// RULE9: idle halts unit only if idle-halt set
// RULE10: mode register bit layout
// RULE11: status register bit layout
// RULE12: status resets to shifter-empty and rx-quiet
// RULE13: baud equals clock over sixteen times divisor+1
// RULE14: sleep-aborted character discarded without error
module ulp_uart_pair
  import ulp_pkg::*;
#(
  parameter int NUM = 2
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  input  wire logic            sleepReq,
  input  wire logic            idleReq,
  input  wire logic [NUM-1:0]  serialInPin,
  output logic [NUM-1:0]       serialOutPin,
  output logic [NUM-1:0]       rxIrqFlag,
  output logic                 wakeUp,
  output logic                 irq
);
  typedef enum logic [1:0] {IDLE_S, START_S, DATA_S, STOP_S} ulp_rx_type;

  ulp_apb_req_type req;
  ulp_power_type   pwr;
  logic [NUM-1:0] inMeta, inSync, inPrev;
  logic [15:0] modeReg [NUM];
  logic [15:0] statReg [NUM];
  logic [15:0] baudReg [NUM];
  logic [15:0] rxWord  [NUM];
  logic [8:0]  txShift [NUM];
  logic [3:0]  txBits  [NUM];
  logic [19:0] txDiv   [NUM];
  logic [8:0]  rxShift [NUM];
  logic [3:0]  rxBits  [NUM];
  logic [15:0] rxDiv   [NUM];
  ulp_rx_type  rxState [NUM];
  logic [NUM-1:0] unitRun, wakeEdge, rxDone, rxGood;
  logic [NUM-1:0] irqStat, irqMask, sleepPrev;
  logic [1:0]  sleepSync, idleSync;
  logic        wrEn, rdEn;
  logic [11:0] wIdx;

  // registers sit one per aligned word: the index is the byte address / 4
  assign wIdx = {2'b00, paddr[11:2]};

  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};
  assign wrEn = req.sel && req.enable && req.write;
  assign rdEn = req.sel && !req.enable && !req.write;

  // pins and power requests come from outside; two flops first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inMeta    <= '1;
      inSync    <= '1;
      sleepSync <= '0;
      idleSync  <= '0;
    end else begin
      inMeta    <= serialInPin;
      inSync    <= inMeta;
      sleepSync <= {sleepSync[0], sleepReq};
      idleSync  <= {idleSync[0], idleReq};
    end
  end
  assign pwr = '{sleep: sleepSync[1], idle: idleSync[1]};

  // channel that a register index belongs to, or -1
  function automatic int chanOf(input logic [11:0] a);
    if (a >= MODE1_OFS && a <= BAUD2_OFS) begin
      return (a >= MODE2_OFS) ? 1 : 0;
    end
    return -1;
  endfunction : chanOf

  function automatic logic [11:0] baseOf(input int c);
    return (c == 1) ? MODE2_OFS : MODE1_OFS;
  endfunction : baseOf

  for (genvar i = 0; i < NUM; i++) begin : g_ch
    logic [11:0] ofs;
    logic        sel;
    logic        inBit;
    logic [15:0] divTop;
    assign sel = (chanOf(wIdx) == i);
    assign ofs = wIdx - baseOf(i);
    assign inBit = modeReg[i][MODE_LOOP] ? serialOutPin[i] : inSync[i];
    assign divTop = baudReg[i];
    // RULE1: clocks not gated; unitRun drops so tx and rx stop in sleep
    // RULE9: idle stops unit only with idle-halt set
    assign unitRun[i] = modeReg[i][MODE_ON] && !pwr.sleep &&
                        !(pwr.idle && modeReg[i][MODE_IDLEH]);
    // RULE5: falling edge, armed from the cycle after sleep with wake set
    // RULE6: independent of rx level select
    // RULE8: only while unit on
    assign wakeEdge[i] = pwr.sleep && sleepPrev[i] &&
                         modeReg[i][MODE_WAKE] && modeReg[i][MODE_ON] &&
                         inPrev[i] && !inSync[i];
    assign rxDone[i] = unitRun[i] && rxState[i] == STOP_S &&
                       rxDiv[i] == divTop && rxBits[i] == 4'(OVERSAMPLE-1);
    assign rxGood[i] = rxDone[i] && inBit;

    // register file; RULE4: nothing here reacts to sleep
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        modeReg[i] <= MODE_RESET;
        baudReg[i] <= '0;
      end else if (wrEn && sel) begin
        // RULE10: mode layout, alt-pin on first unit only
        if (ofs == 12'h000) begin
          modeReg[i] <= pwdata[15:0] & ((i == 0) ? MODE1_MASK : MODE2_MASK);
        end
        if (ofs == 12'h008) begin
          baudReg[i] <= pwdata[15:0];
        end
      end
    end

    // transmitter
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        txShift[i] <= '1;
        txBits[i]  <= '0;
        txDiv[i]   <= '0;
        serialOutPin[i] <= 1'b1;
      end else if (pwr.sleep) begin
        // RULE2: abort frame, line idles high
        txBits[i] <= '0;
        txDiv[i]  <= '0;
        serialOutPin[i] <= 1'b1;
      end else if (!unitRun[i] || !statReg[i][ST_TXON]) begin
        serialOutPin[i] <= 1'b1;
      end else if (statReg[i][ST_BRK]) begin
        serialOutPin[i] <= 1'b0;
      end else if (wrEn && sel && ofs == 12'h004 && txBits[i] == 0) begin
        txShift[i] <= {1'b1, pwdata[7:0]};
        txBits[i]  <= 4'(FRAME_BITS);
        serialOutPin[i] <= 1'b0;
      end else if (txBits[i] != 0) begin
        // RULE13: bit time of sixteen times (divisor+1) clocks
        // a full divisor needs twenty bits of bit-time count
        if (txDiv[i] == 20'((32'(divTop) + 1) * OVERSAMPLE - 1)) begin
          txDiv[i]   <= '0;
          txBits[i]  <= txBits[i] - 4'd1;
          serialOutPin[i] <= (txBits[i] == 1) ? 1'b1 : txShift[i][0];
          txShift[i] <= {1'b1, txShift[i][8:1]};
        end else begin
          txDiv[i] <= txDiv[i] + 20'd1;
        end
      end
    end

    // receiver: sixteen samples per bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        rxState[i] <= IDLE_S;
        rxShift[i] <= '0;
        rxBits[i]  <= '0;
        rxDiv[i]   <= '0;
        rxWord[i]  <= '0;
        inPrev[i]  <= 1'b1;
      end else begin
        inPrev[i] <= inSync[i];
        if (pwr.sleep || !unitRun[i]) begin
          // RULE3: reception aborted
          // RULE14: partial character dropped
          rxState[i] <= IDLE_S;
          rxDiv[i]   <= '0;
          rxBits[i]  <= '0;
        end else if (rxDiv[i] != divTop) begin
          rxDiv[i] <= rxDiv[i] + 16'd1;
        end else begin
          rxDiv[i]  <= '0;
          rxBits[i] <= rxBits[i] + 4'd1;
          unique case (rxState[i])
            IDLE_S: begin
              rxBits[i] <= '0;
              if (!inBit) rxState[i] <= START_S;
            end
            START_S: if (rxBits[i] == 4'd7) begin
              rxBits[i]  <= '0;
              rxShift[i] <= '0;
              rxState[i] <= inBit ? IDLE_S : DATA_S;
            end
            DATA_S: if (rxBits[i] == 4'(OVERSAMPLE-1)) begin
              rxShift[i] <= {1'b1, rxShift[i][8:1]};
              rxShift[i][7] <= inBit;
              if (rxShift[i][0]) rxState[i] <= STOP_S;
            end
            STOP_S: if (rxBits[i] == 4'(OVERSAMPLE-1)) begin
              rxState[i] <= IDLE_S;
              if (!statReg[i][ST_AVAIL] || (rdEn && sel && ofs == 12'h006))
                rxWord[i] <= {8'h00, rxShift[i][8:1]};
            end
          endcase
        end
      end
    end

    // status register
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        // RULE12: only shifter-empty and rx-quiet set
        statReg[i] <= STAT_RESET;
      end else begin
        // RULE11: status layout; software bits writable
        if (wrEn && sel && ofs == 12'h002) begin
          statReg[i] <= (statReg[i] & ~STAT_WMASK) |
                        (pwdata[15:0] & STAT_WMASK);
        end
        statReg[i][ST_EMPTY] <= (txBits[i] == 0);
        statReg[i][ST_TXBF]  <= (txBits[i] != 0);
        statReg[i][ST_QUIET] <= (rxState[i] == IDLE_S);
        if (rxDone[i]) begin
          statReg[i][ST_FRAMING_FAULT] <= !inBit;
          if (statReg[i][ST_AVAIL] && !(rdEn && sel && ofs == 12'h006))
            statReg[i][ST_OVERRUN_FAULT] <= 1'b1;
          statReg[i][ST_AVAIL] <= 1'b1;
        end else if (rdEn && sel && ofs == 12'h006) begin
          statReg[i][ST_AVAIL] <= 1'b0;
        end
      end
    end

    // interrupt status: set wins over write-one clear
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        irqStat[i]   <= 1'b0;
        sleepPrev[i] <= 1'b0;
      end else begin
        sleepPrev[i] <= pwr.sleep && modeReg[i][MODE_WAKE];
        if (rxDone[i] || wakeEdge[i]) begin
          irqStat[i] <= 1'b1;
        end else if (wrEn && wIdx == IRQST_OFS && pwdata[i]) begin
          irqStat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqMask <= '0;
    end else if (wrEn && wIdx == IRQMSK_OFS) begin
      irqMask <= pwdata[NUM-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq       <= 1'b0;
      wakeUp    <= 1'b0;
      rxIrqFlag <= '0;
    end else begin
      irq       <= |(irqStat & irqMask);
      rxIrqFlag <= irqStat;
      // RULE7: wake only for enabled rx interrupt
      wakeUp    <= pwr.sleep && |(irqStat & irqMask);
    end
  end

  // apb: zero wait states, read data captured in setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'b00);
      if (rdEn) begin
        prdata <= '0;
        for (int c = 0; c < NUM; c++) begin
          if (wIdx == baseOf(c)) prdata <= {16'h0000, modeReg[c]};
          if (wIdx == baseOf(c) + 12'h002) prdata <= {16'h0000, statReg[c]};
          if (wIdx == baseOf(c) + 12'h006) prdata <= {16'h0000, rxWord[c]};
          if (wIdx == baseOf(c) + 12'h008) prdata <= {16'h0000, baudReg[c]};
        end
        if (wIdx == IRQST_OFS) prdata <= 32'(irqStat);
        if (wIdx == IRQMSK_OFS) prdata <= 32'(irqMask);
        if (wIdx == PWR_OFS) prdata <= {30'h0, pwr.idle, pwr.sleep};
      end
    end
  end

  // RULE2: line high while asleep
  sleep_line_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    pwr.sleep |=> serialOutPin == '1) else $error("tx line low in sleep");
  // RULE12: reset value of status
  stat_reset_a: assert property (@(posedge clk) // RULE12
    $rose(rst_n) |-> statReg[0] == STAT_RESET && statReg[1] == STAT_RESET)
    else $error("status reset");
  // RULE7: no wake without enabled flag
  wake_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    wakeUp |-> $past(|(irqStat & irqMask))) else $error("bad wake");
  // RULE4: baud kept across sleep
  sleep_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    pwr.sleep && !wrEn |=> $stable(baudReg[0]) && $stable(modeReg[0]))
    else $error("register changed in sleep");

  // steps of an edge wake: sticky flag first, then the flag output
  sequence flagUp_s;
    irqStat[0] ##1 rxIrqFlag[0];
  endsequence
  // steps of a sleep entry on the line: high and held high
  sequence lineHigh_s;
    serialOutPin[0] ##1 serialOutPin[0];
  endsequence

  // RULE5: falling edge in sleep raises flag
  wake_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    wakeEdge[0] |=> flagUp_s)
    else $error("edge did not raise flag");
  // RULE6: second channel flags edge likewise
  wake_any_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    wakeEdge[1] |=> irqStat[1])
    else $error("edge did not raise flag");
  // RULE2: frame cut at sleep entry
  tx_abort_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    $rose(pwr.sleep) |=> lineHigh_s)
    else $error("tx line low after sleep entry");
  // RULE3: receiver idles in sleep
  rx_abort_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    pwr.sleep |=> rxState[0] == IDLE_S)
    else $error("reception kept in sleep");
  // RULE14: no word and no error from aborted frame
  drop_char_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    pwr.sleep |=> $stable(rxWord[0]) && !$rose(statReg[0][ST_FRAMING_FAULT]))
    else $error("aborted character stored");
  // RULE8: no flag while unit off
  unit_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    !modeReg[1][MODE_ON] && !irqStat[1] |=> !irqStat[1])
    else $error("flag raised with unit off");
  // RULE9: idle-halt stops the unit
  idle_halt_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    pwr.idle && modeReg[1][MODE_IDLEH] |-> !unitRun[1])
    else $error("unit runs in idle with halt set");
  // RULE9: without halt the unit keeps running
  idle_run_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    modeReg[1][MODE_ON] && !pwr.sleep && !modeReg[1][MODE_IDLEH]
    |-> unitRun[1])
    else $error("unit stopped in idle without halt");
  // RULE7: enabled flag in sleep wakes the device
  wake_level_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    pwr.sleep && |(irqStat & irqMask) |=> wakeUp)
    else $error("no wake for enabled flag");
  // ready lasts a single access cycle
  apb_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule : ulp_uart_pair

// [test/ulp_line_peer.sv]
// ulp line peer: remote serial transceiver driving the unit inputs
module ulp_line_peer
#(
  parameter int BIT_CYC = 16
) (
  input  wire logic       clk,
  output logic      [1:0] serialInPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // an idle line rests high, as a real transceiver leaves it
  initial serialInPin = 2'b11;
  // start bit, eight data bits lsb first, one stop bit
  task automatic send_frame(input int ch, input logic [7:0] data);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serialInPin[ch] <= frame[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : send_frame
  // short low pulse: just a falling edge, no valid character
  task automatic pulse_low(input int ch);
    serialInPin[ch] <= 1'b0;
    repeat (4) @(posedge clk);
    serialInPin[ch] <= 1'b1;
  endtask : pulse_low
endmodule : ulp_line_peer

// [test/uart_low_power_and_regs_tb_top.sv]
// bench for the two-channel serial unit: registers, sleep and idle
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin \
  nMismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module uart_low_power_and_regs_tb_top
  import ulp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rstN;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic        pready;
  logic        pslverr;
  logic        rerr;
  logic        sleepReq;
  logic        idleReq;
  logic [1:0]  serialInPin;
  logic [1:0]  serialOutPin;
  logic [1:0]  rxIrqFlag;
  logic        wakeUp;
  logic        irq;
  int          nMismatch = 0;
  int          cmpCount = 0;
  int          n;
  logic [11:0] modeOfs [2] = '{MODE1_OFS, MODE2_OFS};
  logic [15:0] modeMsk [2] = '{MODE1_MASK, MODE2_MASK};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ulp_uart_pair #(.NUM(2)) i_dut (
    .clk(clk), .rst_n(rstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sleepReq(sleepReq),
    .idleReq(idleReq), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin), .rxIrqFlag(rxIrqFlag), .wakeUp(wakeUp),
    .irq(irq)
  );
  ulp_line_peer #(.BIT_CYC(16)) i_peer (
    .clk(clk), .serialInPin(serialInPin)
  );

  // setup then access; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [1:0] lo = 2'b00);
    int w;
    w = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    // a is the register index; the byte address is four times it
    paddr   <= {a[9:0], lo};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 50) begin
      @(posedge clk);
      w++;
    end
    if (w == 50) nMismatch++;
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdata, {16'h0000, e})
  endtask : rd_chk

  // edge on the input line while asleep; flag, wake and irq compared
  task automatic edge_case(input int ch, input logic [15:0] mode,
                           input logic [1:0] msk, input logic ef,
                           input logic ew);
    apb(1'b1, modeOfs[ch], {16'h0000, mode});
    apb(1'b1, IRQMSK_OFS, {30'h0000_0000, msk});
    sleepReq <= 1'b1;
    repeat (5) @(posedge clk);
    i_peer.pulse_low(ch);
    repeat (20) @(posedge clk);
    `CHK(rxIrqFlag[ch], ef)
    `CHK(wakeUp, ew)
    `CHK(irq, ew)
    sleepReq <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b1, IRQST_OFS, 32'h0000_0003);
    repeat (2) @(posedge clk);
    `CHK(rxIrqFlag[ch], 1'b0)
    apb(1'b1, modeOfs[ch], 32'h0000_0000);
  endtask : edge_case

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finalReport

  // hang guard: all tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    finalReport();
  end

  initial begin
    rstN = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sleepReq = 1'b0;
    idleReq = 1'b0;
    repeat (3) @(posedge clk);
    rstN <= 1'b1;
    rd_chk(STAT1_OFS, STAT_RESET);
    rd_chk(STAT2_OFS, STAT_RESET);
    rd_chk(BAUD2_OFS, 16'h0000);
    rd_chk(12'h0100, 16'h0000);
    apb(1'b0, 12'h0201, 32'h0000_0000, 2'b01);
    `CHK(rerr, 1'b1)
    for (int i = 0; i < 2; i++) begin
      rd_chk(modeOfs[i], MODE_RESET);
      apb(1'b1, modeOfs[i], 32'h0000_ffff);
      rd_chk(modeOfs[i], modeMsk[i]);
      apb(1'b1, modeOfs[i], 32'h0000_0000);
    end
    apb(1'b1, BAUD1_OFS, 32'h0000_beef);
    rd_chk(BAUD1_OFS, 16'hbeef);
    apb(1'b1, BAUD1_OFS, 32'h0000_0000);
    $display("test registers done");
    // sleep lands mid-transmit and mid-receive on channel 0
    apb(1'b1, MODE1_OFS, 32'h0000_8000);
    apb(1'b1, STAT1_OFS, 32'h0000_04c0);
    apb(1'b1, TXW1_OFS, 32'h0000_0000);
    fork
      i_peer.send_frame(0, 8'hff);
    join_none
    repeat (60) @(posedge clk);
    `CHK(serialOutPin[0], 1'b0)
    sleepReq <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(serialOutPin[0], 1'b1)
    repeat (100) @(posedge clk);
    `CHK(serialOutPin[0], 1'b1)
    sleepReq <= 1'b0;
    repeat (10) @(posedge clk);
    rd_chk(MODE1_OFS, 16'h8000);
    apb(1'b0, STAT1_OFS, 32'h0000_0000);
    `CHK(rdata & 32'h0000_fcef, 32'h0000_04c0)
    $display("test sleep abort done");
    edge_case(0, 16'h8080, 2'b01, 1'b1, 1'b1);
    edge_case(0, 16'h8080, 2'b00, 1'b1, 1'b0);
    edge_case(1, 16'h0080, 2'b10, 1'b0, 1'b0);
    $display("test edge wake done");
    // idle: halt bit decides whether a start bit appears
    apb(1'b1, BAUD2_OFS, 32'h0000_0001);
    apb(1'b1, STAT2_OFS, 32'h0000_0400);
    for (int h = 1; h >= 0; h--) begin
      apb(1'b1, MODE2_OFS, 32'h0000_8000 | (h << MODE_IDLEH));
      idleReq <= 1'b1;
      repeat (5) @(posedge clk);
      apb(1'b1, TXW2_OFS, 32'h0000_00ff);
      n = 0;
      while (serialOutPin[1] === 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      `CHK(n < 100, h == 0)
      n = 0;
      while (h == 0 && serialOutPin[1] === 1'b0 && n < 100) begin
        @(posedge clk);
        n++;
      end
      if (h == 0) `CHK(n, OVERSAMPLE * 2)
      idleReq <= 1'b0;
      repeat (400) @(posedge clk);
    end
    $display("test idle and baud done");
    finalReport();
  end
endmodule : uart_low_power_and_regs_tb_top
